// ==== logic/slg_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the PLL lock gate.
// Assumes byte addresses on a 12-bit register port with one 32-bit word per register.
`ifndef SLG_REGS_SVH
`define SLG_REGS_SVH

// Register byte offsets.
`define SLG_OFS_SOFT_RST 12'h000
`define SLG_OFS_CONTROL 12'h004
`define SLG_OFS_ADV_ABILITY 12'h008
`define SLG_OFS_TX_CFG 12'h00c
`define SLG_OFS_RX_CFG 12'h010
`define SLG_OFS_AUX_CFG 12'h014
`define SLG_OFS_STATUS 12'h018
`define SLG_OFS_INT_STAT 12'h01c
`define SLG_OFS_INT_MASK 12'h020
`define SLG_OFS_LOCK_CTL 12'h088

// Field positions.
`define SLG_LOCK_EN_BIT 0
`define SLG_SOFT_RST_BIT 0
`define SLG_STAT_LOCK_BIT 0
`define SLG_STAT_BUSY_BIT 1
`define SLG_STAT_SETTLED_BIT 2
`define SLG_STAT_POWER_BIT 3
`define SLG_EVT_LOCK_UP 0
`define SLG_EVT_LOCK_DOWN 1
`define SLG_EVT_SETTLED 2
`define SLG_EVT_RST_DONE 3

// Reset values and patterns.
`define SLG_RST_WORD 32'h0000_0000
`define SLG_RST_EVT 4'h0
`define SLG_RST_CNT 9'h000
`define SLG_AUX_PWR_PATTERN 32'h0000_000b

// Timing: clock period, regulator settling and reference clock lock cycles.
`define SLG_CNT_W 9
`define SLG_CLK_PERIOD_NS 8
`define SLG_REG_SETTLE_NS 1000
`define SLG_REFCLK_PERIOD_NS 8
`define SLG_REFCLK_LOCK_CYC 200
`define SLG_SETTLE_CYC (((`SLG_REG_SETTLE_NS + `SLG_CLK_PERIOD_NS - 1) / `SLG_CLK_PERIOD_NS) + \
  ((`SLG_REFCLK_LOCK_CYC * `SLG_REFCLK_PERIOD_NS + `SLG_CLK_PERIOD_NS - 1) / `SLG_CLK_PERIOD_NS))
`define SLG_SOFT_RST_CYC 16

`endif

// ==== logic/slg_pkg.sv ====
// Types shared by the PLL lock gate and its synchroniser.
// Assumes the constants of slg_regs.svh for every width and value.
package slg_pkg;

  typedef logic [31:0] slg_word_t;
  typedef logic [11:0] slg_addr_t;
  typedef logic [3:0] slg_evt_t;
  typedef logic [8:0] slg_cnt_t;

  // Power-up tracking of the PLL after the auxiliary register enables it.
  typedef enum logic [1:0] {
    SLG_PWR_OFF,
    SLG_PWR_SETTLE,
    SLG_PWR_READY
  } slg_pwr_e;

  // Whole state of the lock gate.
  typedef struct packed {
    logic lock_en_reg;
    logic soft_busy_reg;
    slg_cnt_t soft_cnt_reg;
    slg_word_t control_reg;
    slg_word_t adv_ability_reg;
    slg_word_t tx_cfg_reg;
    slg_word_t rx_cfg_reg;
    slg_word_t aux_cfg_reg;
    logic power_reg;
    slg_pwr_e pwr_state_reg;
    slg_cnt_t settle_cnt_reg;
    logic lock_prev_reg;
    logic lock_rst_reg;
    slg_evt_t int_stat_reg;
    slg_evt_t int_mask_reg;
    slg_word_t rdata_reg;
    logic irq_reg;
  } slg_state_s;

  // State of the two-flop synchroniser.
  typedef struct packed {
    logic meta_reg;
    logic sync_reg;
  } slg_sync_s;

endpackage

// ==== logic/slg_sync.sv ====
// Two-flop synchroniser for a level arriving from another clock domain.
// Assumes the input may change at any time relative to core_clk.
module slg_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  import slg_pkg::*;

  slg_sync_s s_reg;
  slg_sync_s s_next;

  //////////////////////////////////////////////////////////////////////////////
  // The first flop feeds only the second one.
  always_comb begin
    s_next = s_reg;
    s_next.meta_reg = async_in;
    s_next.sync_reg = s_reg.meta_reg;
  end

  // State register, cleared to unlocked on reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.sync_reg;

endmodule

// ==== logic/slg_lock_gate.sv ====
// SERDES PLL lock gate with the SGMII soft reset and configuration registers.
// Assumes a plain register port on core_clk and a PLL lock level from another domain.
//
// Functional notes
// - Lock control bit 0 is gate enable, resets 0.
// - Lock control bits 31 to 1 read zero.
// - Enable low: lock never resets the SGMII block.
// - Enable high: lost lock resets the SGMII block.
// - Lock status reads one unless gate is enabled.
// - PLL needs regulator settle plus 200 cycles.
// - Auxiliary enable pattern powers the SERDES PLL.
`include "slg_regs.svh"

module slg_lock_gate (
  input wire logic core_clk,
  input wire logic rst,
  input wire slg_pkg::slg_addr_t reg_addr,
  input wire slg_pkg::slg_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output slg_pkg::slg_word_t reg_rdata,
  input wire logic pll_lock_raw,
  output logic pll_power_en,
  output logic sgmii_soft_rst,
  output logic sgmii_lock_rst,
  output slg_pkg::slg_word_t sgmii_control,
  output slg_pkg::slg_word_t sgmii_adv_ability,
  output slg_pkg::slg_word_t sgmii_tx_cfg,
  output slg_pkg::slg_word_t sgmii_rx_cfg,
  output logic irq
);
  import slg_pkg::*;

  slg_state_s s_reg;
  slg_state_s s_next;
  logic lock_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True when a strobe addresses the given register.
  function automatic logic reg_hit(input slg_addr_t addr, input slg_addr_t ofs);
    reg_hit = (addr == ofs);
  endfunction

  // Lock status as software sees it: forced high while the gate is off.
  function automatic logic lock_view(input logic lock_en, input logic lock_now);
    lock_view = lock_en ? lock_now : 1'b1;
  endfunction

  // Read multiplexer; unmapped addresses read zero.
  function automatic slg_word_t read_word(input slg_addr_t addr, input slg_state_s s, input logic lock_now);
    slg_word_t w;
    w = `SLG_RST_WORD;
    if (reg_hit(addr, `SLG_OFS_SOFT_RST)) begin
      w[`SLG_SOFT_RST_BIT] = s.soft_busy_reg;
    end else if (reg_hit(addr, `SLG_OFS_CONTROL)) begin
      w = s.control_reg;
    end else if (reg_hit(addr, `SLG_OFS_ADV_ABILITY)) begin
      w = s.adv_ability_reg;
    end else if (reg_hit(addr, `SLG_OFS_TX_CFG)) begin
      w = s.tx_cfg_reg;
    end else if (reg_hit(addr, `SLG_OFS_RX_CFG)) begin
      w = s.rx_cfg_reg;
    end else if (reg_hit(addr, `SLG_OFS_AUX_CFG)) begin
      w = s.aux_cfg_reg;
    end else if (reg_hit(addr, `SLG_OFS_STATUS)) begin
      w[`SLG_STAT_LOCK_BIT] = lock_view(s.lock_en_reg, lock_now);
      w[`SLG_STAT_BUSY_BIT] = s.soft_busy_reg;
      w[`SLG_STAT_SETTLED_BIT] = (s.pwr_state_reg == SLG_PWR_READY);
      w[`SLG_STAT_POWER_BIT] = s.power_reg;
    end else if (reg_hit(addr, `SLG_OFS_INT_STAT)) begin
      w[3:0] = s.int_stat_reg;
    end else if (reg_hit(addr, `SLG_OFS_INT_MASK)) begin
      w[3:0] = s.int_mask_reg;
    end else if (reg_hit(addr, `SLG_OFS_LOCK_CTL)) begin
      w[`SLG_LOCK_EN_BIT] = s.lock_en_reg;
    end
    read_word = w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // PLL lock crossing into the register clock domain.
  slg_sync u_lock_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pll_lock_raw),
    .sync_out(lock_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for every register of the block.
  always_comb begin
    slg_evt_t evt;
    slg_evt_t clr;
    logic pwr_on;
    evt = `SLG_RST_EVT;
    clr = `SLG_RST_EVT;
    pwr_on = 1'b0;
    s_next = s_reg;

    // Lock gate enable; upper bits are not stored.
    if (reg_wr && reg_hit(reg_addr, `SLG_OFS_LOCK_CTL)) begin
      s_next.lock_en_reg = reg_wdata[`SLG_LOCK_EN_BIT];
    end

    // Soft reset runs a fixed count, then clears itself and reports done.
    if (s_reg.soft_busy_reg) begin
      if (s_reg.soft_cnt_reg == `SLG_CNT_W'(`SLG_SOFT_RST_CYC - 1)) begin
        s_next.soft_busy_reg = 1'b0;
        s_next.soft_cnt_reg = `SLG_RST_CNT;
        evt[`SLG_EVT_RST_DONE] = 1'b1;
      end else begin
        s_next.soft_cnt_reg = s_reg.soft_cnt_reg + `SLG_CNT_W'(1);
      end
    end else if (reg_wr && reg_hit(reg_addr, `SLG_OFS_SOFT_RST) && reg_wdata[`SLG_SOFT_RST_BIT]) begin
      s_next.soft_busy_reg = 1'b1;
      s_next.soft_cnt_reg = `SLG_RST_CNT;
    end

    // Configuration registers: cleared during soft reset, writable otherwise.
    if (s_reg.soft_busy_reg) begin
      s_next.control_reg = `SLG_RST_WORD;
      s_next.adv_ability_reg = `SLG_RST_WORD;
      s_next.tx_cfg_reg = `SLG_RST_WORD;
      s_next.rx_cfg_reg = `SLG_RST_WORD;
      s_next.aux_cfg_reg = `SLG_RST_WORD;
    end else if (reg_wr) begin
      if (reg_hit(reg_addr, `SLG_OFS_CONTROL)) begin
        s_next.control_reg = reg_wdata;
      end
      if (reg_hit(reg_addr, `SLG_OFS_ADV_ABILITY)) begin
        s_next.adv_ability_reg = reg_wdata;
      end
      if (reg_hit(reg_addr, `SLG_OFS_TX_CFG)) begin
        s_next.tx_cfg_reg = reg_wdata;
      end
      if (reg_hit(reg_addr, `SLG_OFS_RX_CFG)) begin
        s_next.rx_cfg_reg = reg_wdata;
      end
      if (reg_hit(reg_addr, `SLG_OFS_AUX_CFG)) begin
        s_next.aux_cfg_reg = reg_wdata;
      end
    end

    // PLL power follows the auxiliary register holding the enable pattern.
    pwr_on = (s_reg.aux_cfg_reg == `SLG_AUX_PWR_PATTERN);
    s_next.power_reg = pwr_on;

    // Power-up tracking: regulator settling plus reference cycles to lock.
    unique case (s_reg.pwr_state_reg)
      SLG_PWR_OFF: begin
        s_next.settle_cnt_reg = `SLG_RST_CNT;
        if (pwr_on) begin
          s_next.pwr_state_reg = SLG_PWR_SETTLE;
        end
      end
      SLG_PWR_SETTLE: begin
        if (!pwr_on) begin
          s_next.pwr_state_reg = SLG_PWR_OFF;
          s_next.settle_cnt_reg = `SLG_RST_CNT;
        end else if (s_reg.settle_cnt_reg == `SLG_CNT_W'(`SLG_SETTLE_CYC - 1)) begin
          s_next.pwr_state_reg = SLG_PWR_READY;
          evt[`SLG_EVT_SETTLED] = 1'b1;
        end else begin
          s_next.settle_cnt_reg = s_reg.settle_cnt_reg + `SLG_CNT_W'(1);
        end
      end
      SLG_PWR_READY: begin
        if (!pwr_on) begin
          s_next.pwr_state_reg = SLG_PWR_OFF;
          s_next.settle_cnt_reg = `SLG_RST_CNT;
        end
      end
    endcase

    // Lock edges count as events only while the gate is enabled.
    s_next.lock_prev_reg = lock_sync;
    if (s_reg.lock_en_reg && lock_sync && !s_reg.lock_prev_reg) begin
      evt[`SLG_EVT_LOCK_UP] = 1'b1;
    end
    if (s_reg.lock_en_reg && !lock_sync && s_reg.lock_prev_reg) begin
      evt[`SLG_EVT_LOCK_DOWN] = 1'b1;
    end

    // The lock function may reset the SGMII block only through the gate.
    s_next.lock_rst_reg = s_reg.lock_en_reg && !lock_sync;

    // Sticky events: write one to clear, a new event wins over the clear.
    if (reg_wr && reg_hit(reg_addr, `SLG_OFS_INT_STAT)) begin
      clr = reg_wdata[3:0];
    end
    s_next.int_stat_reg = (s_reg.int_stat_reg & ~clr) | evt;
    if (reg_wr && reg_hit(reg_addr, `SLG_OFS_INT_MASK)) begin
      s_next.int_mask_reg = reg_wdata[3:0];
    end
    s_next.irq_reg = |(s_next.int_stat_reg & s_next.int_mask_reg);

    // Read data stand only in the cycle after the read strobe.
    if (reg_rd) begin
      s_next.rdata_reg = read_word(reg_addr, s_reg, lock_sync);
    end else begin
      s_next.rdata_reg = `SLG_RST_WORD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; everything clears on reset, so the gate starts disabled.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken straight from the state register.
  assign reg_rdata = s_reg.rdata_reg;
  assign pll_power_en = s_reg.power_reg;
  assign sgmii_soft_rst = s_reg.soft_busy_reg;
  assign sgmii_lock_rst = s_reg.lock_rst_reg;
  assign sgmii_control = s_reg.control_reg;
  assign sgmii_adv_ability = s_reg.adv_ability_reg;
  assign sgmii_tx_cfg = s_reg.tx_cfg_reg;
  assign sgmii_rx_cfg = s_reg.rx_cfg_reg;
  assign irq = s_reg.irq_reg;

endmodule

// ==== testbench/slg_lock_gate_monitor.sv ====
// Port checker of the PLL lock gate.
// Assumes it is bound to slg_lock_gate and sees only its ports.
`include "slg_regs.svh"
module slg_lock_gate_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire slg_pkg::slg_addr_t reg_addr,
  input wire slg_pkg::slg_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire slg_pkg::slg_word_t reg_rdata,
  input wire logic pll_lock_raw,
  input wire logic pll_power_en,
  input wire logic sgmii_soft_rst,
  input wire logic sgmii_lock_rst,
  input wire slg_pkg::slg_word_t sgmii_control,
  input wire slg_pkg::slg_word_t sgmii_adv_ability,
  input wire slg_pkg::slg_word_t sgmii_tx_cfg,
  input wire slg_pkg::slg_word_t sgmii_rx_cfg,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import slg_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Read data, lock control, power, soft reset and lock reset timing.
  rdata_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("rdata not idle");
  lock_rsvd_zero_a: assert property (reg_rd && reg_addr == `SLG_OFS_LOCK_CTL
    |=> reg_rdata[31:1] == 31'h0) else $error("lock control reserved bits set");
  lock_off_quiet_a: assert property (reg_wr && reg_addr == `SLG_OFS_LOCK_CTL && !reg_wdata[0]
    |-> ##2 !sgmii_lock_rst) else $error("lock reset with gate off");
  lock_rst_sync_a: assert property (sgmii_lock_rst |-> !$past(pll_lock_raw, 3))
    else $error("lock reset without synced loss");
  power_on_a: assert property (reg_wr && reg_addr == `SLG_OFS_AUX_CFG
    && reg_wdata == `SLG_AUX_PWR_PATTERN && !sgmii_soft_rst |-> ##2 pll_power_en) else $error("power not on");
  power_off_a: assert property (reg_wr && reg_addr == `SLG_OFS_AUX_CFG
    && reg_wdata != `SLG_AUX_PWR_PATTERN && !sgmii_soft_rst |-> ##2 !pll_power_en) else $error("power not off");
  soft_len_a: assert property (reg_wr && reg_addr == `SLG_OFS_SOFT_RST && reg_wdata[0]
    && !sgmii_soft_rst |=> sgmii_soft_rst[*8] ##1 sgmii_soft_rst[*8] ##1 !sgmii_soft_rst)
    else $error("soft reset length");
  cfg_cleared_a: assert property (sgmii_soft_rst[*3] |-> sgmii_control == '0 && sgmii_rx_cfg == '0)
    else $error("config not cleared");
  cover property ($fell(sgmii_soft_rst));
  cover property ($rose(sgmii_lock_rst));
  cover property ($rose(irq));
endmodule

bind slg_lock_gate slg_lock_gate_monitor u_mon (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_lock_raw(pll_lock_raw),
  .pll_power_en(pll_power_en), .sgmii_soft_rst(sgmii_soft_rst), .sgmii_lock_rst(sgmii_lock_rst),
  .sgmii_control(sgmii_control), .sgmii_adv_ability(sgmii_adv_ability), .sgmii_tx_cfg(sgmii_tx_cfg),
  .sgmii_rx_cfg(sgmii_rx_cfg), .irq(irq));

// ==== testbench/slg_pll_model.sv ====
// Behavioural SERDES PLL on the far side of the lock gate.
// Assumes power_en comes from the gate and drop is commanded by the bench.
module slg_pll_model #(
  parameter int SETTLE_NS = 2600
) (
  input wire logic power_en,
  input wire logic drop,
  output logic lock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ready = 1'b0;
  // Lock comes one regulator settle plus 200 reference cycles after power on, never without power.
  always @(power_en) begin
    ready = 1'b0;
    if (power_en) begin
      ready <= #(SETTLE_NS) 1'b1;
    end
  end
  assign lock = power_en & ready & ~drop;
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench of the PLL lock gate with a PLL model on the far side.
// Assumes the design, the checker and the PLL model are compiled first.
`include "slg_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import slg_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, lock_raw, power_en, soft_rst, lock_rst, irq, drop;
  slg_addr_t reg_addr;
  slg_word_t reg_wdata, reg_rdata, ctl, adv, txc, rxc, d;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  slg_lock_gate DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_lock_raw(lock_raw),
    .pll_power_en(power_en), .sgmii_soft_rst(soft_rst), .sgmii_lock_rst(lock_rst), .sgmii_control(ctl),
    .sgmii_adv_ability(adv), .sgmii_tx_cfg(txc), .sgmii_rx_cfg(rxc), .irq(irq));
  slg_pll_model pll (.power_en(power_en), .drop(drop), .lock(lock_raw));
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 8 ns and a cycle ceiling that cuts a hang short.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input slg_word_t exp, input slg_word_t got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Register port cycles: one-cycle strobes, read data taken the cycle after.
  task automatic wr(input slg_addr_t a, input slg_word_t v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input slg_addr_t a, input slg_word_t exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    if (what != "") chk(what, exp, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, reserved bits, an unmapped place and the gate's effect on lock reset.
  task automatic t_reset();
    rchk("lock_ctl", `SLG_OFS_LOCK_CTL, 32'h0);
    rchk("status", `SLG_OFS_STATUS, 32'h1);
    rchk("unmapped", 12'h0fc, 32'h0);
    wr(`SLG_OFS_LOCK_CTL, 32'hffff_fffe);
    rchk("lock_rsvd", `SLG_OFS_LOCK_CTL, 32'h0);
    wr(`SLG_OFS_LOCK_CTL, 32'hffff_ffff);
    rchk("lock_set", `SLG_OFS_LOCK_CTL, 32'h1);
    rchk("status_true", `SLG_OFS_STATUS, 32'h0);
    chk("lock_rst_on", 32'h1, lock_rst);
    wr(`SLG_OFS_LOCK_CTL, 32'h0);
    repeat (2) @(posedge core_clk);
    #1 chk("lock_rst_off", 32'h0, lock_rst);
  endtask
  // Soft reset, its done event, then the configuration in order.
  task automatic t_soft();
    int n;
    wr(`SLG_OFS_SOFT_RST, 32'h1);
    #1 chk("soft_rst_on", 32'h1, soft_rst);
    wr(`SLG_OFS_CONTROL, 32'h5);
    n = 0;
    d = 32'h1;
    while (d !== 32'h0 && n < 40) begin
      rchk("", `SLG_OFS_SOFT_RST, 32'h0);
      n++;
    end
    chk("soft_done", 32'h0, d);
    chk("soft_rst_off", 32'h0, soft_rst);
    rchk("ctl_refused", `SLG_OFS_CONTROL, 32'h0);
    rchk("int_done", `SLG_OFS_INT_STAT, 32'h8);
    wr(`SLG_OFS_INT_STAT, 32'h8);
    rchk("int_clr", `SLG_OFS_INT_STAT, 32'h0);
    wr(`SLG_OFS_CONTROL, 32'h1);
    wr(`SLG_OFS_ADV_ABILITY, 32'h1);
    wr(`SLG_OFS_TX_CFG, 32'he21);
    wr(`SLG_OFS_RX_CFG, 32'h81021);
    repeat (2) @(posedge core_clk);
    #1 chk("control", 32'h1, ctl);
    chk("adv", 32'h1, adv);
    chk("tx_cfg", 32'he21, txc);
    chk("rx_cfg", 32'h81021, rxc);
  endtask
  // Power up, wait for lock, lose it with the gate on and off, interrupt raised and cleared.
  task automatic t_lock();
    int n;
    wr(`SLG_OFS_AUX_CFG, `SLG_AUX_PWR_PATTERN);
    wr(`SLG_OFS_LOCK_CTL, 32'h1);
    #1 chk("power", 32'h1, power_en);
    rchk("status_wait", `SLG_OFS_STATUS, 32'h8);
    n = 0;
    while (d[0] !== 1'b1 && n < 400) begin
      rchk("", `SLG_OFS_STATUS, 32'h0);
      n++;
    end
    chk("settle_slow", 32'h1, 32'(n > 150));
    rchk("status_lock", `SLG_OFS_STATUS, 32'hd);
    rchk("int_lock", `SLG_OFS_INT_STAT, 32'h5);
    wr(`SLG_OFS_INT_STAT, 32'h5);
    wr(`SLG_OFS_INT_MASK, 32'h2);
    rchk("int_mask", `SLG_OFS_INT_MASK, 32'h2);
    @(posedge core_clk);
    drop <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 chk("lock_rst_loss", 32'h1, lock_rst);
    chk("irq_on", 32'h1, irq);
    rchk("int_loss", `SLG_OFS_INT_STAT, 32'h2);
    rchk("status_loss", `SLG_OFS_STATUS, 32'hc);
    wr(`SLG_OFS_LOCK_CTL, 32'h0);
    repeat (2) @(posedge core_clk);
    #1 chk("lock_rst_gated", 32'h0, lock_rst);
    rchk("status_forced", `SLG_OFS_STATUS, 32'hd);
    wr(`SLG_OFS_INT_STAT, 32'h2);
    repeat (2) @(posedge core_clk);
    #1 chk("irq_off", 32'h0, irq);
    drop <= 1'b0;
    wr(`SLG_OFS_AUX_CFG, 32'h0);
    repeat (2) @(posedge core_clk);
    #1 chk("power_off", 32'h0, power_en);
  endtask
  // Main sequence: 20 cycles of reset, then the scenarios.
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    drop = 1'b0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_soft();
    t_lock();
    end_of_test();
  end
endmodule
